// File: rtl/vosc_pkg.sv
package vosc_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_TIMING = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;
  // ==========================================
  // Control fields
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_PAT_LSB = 1;
  localparam int CTRL_LOSS_LSB = 3;
  localparam int CTRL_LOCKOUT_BIT = 5;
  localparam int CTRL_GENLOCK_BIT = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int DLY_LINE_LSB = 16;
  localparam int TIM_FINE_LSB = 16;
  // ==========================================
  // Encodings
  localparam logic [1:0] PAT_OFF = 2'h0;
  localparam logic [1:0] PAT_BLACK = 2'h1;
  localparam logic [1:0] PAT_BARS = 2'h2;
  localparam logic [1:0] LOSS_NONE = 2'h0;
  localparam logic [1:0] LOSS_MUTE = 2'h1;
  localparam logic [1:0] LOSS_FREEZE = 2'h2;
  localparam logic [1:0] PRES_NONE = 2'h0;
  localparam logic [1:0] PRES_525 = 2'h1;
  localparam logic [1:0] PRES_625 = 2'h2;
  localparam int EV_LOSS = 0;
  localparam int EV_RESTORE = 1;
  localparam int EV_STD = 2;
  localparam int NUM_EV = 3;
  // ==========================================
  // Line standards
  localparam logic [9:0] LINES_525 = 10'h020D;
  localparam logic [9:0] LINES_625 = 10'h0271;
  localparam logic [9:0] SPL_525 = 10'h035A;
  localparam logic [9:0] SPL_625 = 10'h0360;
  localparam logic [9:0] VB_NARROW_525 = 10'h0009;
  localparam logic [9:0] VB_NARROW_625 = 10'h0006;
  localparam logic [9:0] VB_WIDE_525 = 10'h0014;
  localparam logic [9:0] VB_WIDE_625 = 10'h0016;
  localparam logic [9:0] FIRST_LINE = 10'h0001;
  // ==========================================
  // Video levels and buffer
  localparam logic [9:0] BLACK_LEVEL = 10'h0040;
  localparam logic [9:0] BAR_LEVEL [8] = '{10'h03AC, 10'h0344, 10'h02D0, 10'h0270,
                                          10'h01FC, 10'h019C, 10'h0128, 10'h00C4};
  localparam int MEM_AW = 10;
  localparam int MEM_DW = 10;
  localparam int CLK_MHZ = 10;
  localparam int DELAY_MIN_US = 90;
  localparam int DELAY_MIN_CYC = DELAY_MIN_US * CLK_MHZ;
  localparam int PHASE_W = 9;
endpackage

// File: rtl/vosc_line_mem.sv
`timescale 1ns/1ps
`default_nettype none
module vosc_line_mem (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [vosc_pkg::MEM_AW-1:0] waddr_in,
  input wire logic [vosc_pkg::MEM_DW-1:0] wdata_in,
  input wire logic [vosc_pkg::MEM_AW-1:0] raddr_in,
  output logic [vosc_pkg::MEM_DW-1:0] rdata_out
);
  logic [vosc_pkg::MEM_DW-1:0] mem [2**vosc_pkg::MEM_AW];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule
`default_nettype wire

// File: rtl/vosc_top.sv
`timescale 1ns/1ps
`default_nettype none
module vosc_top (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid_in,
  input wire logic [9:0] in_data_in,
  input wire logic in_frame_start_in,
  input wire logic [1:0] in_presence_in,
  input wire logic [8:0] in_sch_phase_in,
  input wire logic ref_present_in,
  input wire logic ref_frame_start_in,
  input wire logic [8:0] ref_sch_phase_in,
  input wire logic [2:0] panel_button_in,
  output logic [2:0] panel_press_out,
  output logic [9:0] vid_data_out,
  output logic vid_blank_out,
  output logic out_std_625_out,
  output logic [8:0] subcarrier_horizontal_phase_out,
  output logic loss_active_out,
  output logic irq_out
);
  typedef enum logic [1:0] {
    VOSC_IDLE = 2'b00,
    VOSC_LOCK = 2'b01,
    VOSC_LOST = 2'b11
  } vosc_state_type;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ==========================================
  // Register file over APB
  logic [6:0] ctrl, next_ctrl;
  logic [9:0] dly_samples, next_dly_samples;
  logic [9:0] dly_lines, next_dly_lines;
  logic [9:0] h_offset, next_h_offset;
  logic [8:0] fine_phase, next_fine_phase;
  logic [2:0] int_stat, next_int_stat;
  logic [2:0] int_mask, next_int_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic [2:0] events;
  logic access, wr_fire, mapped;
  vosc_state_type state;

  assign access = psel && penable && !pready;
  assign wr_fire = psel && penable && pready && pwrite;
  assign mapped = addr_is(paddr, vosc_pkg::ADDR_CTRL) || addr_is(paddr, vosc_pkg::ADDR_DELAY) ||
                  addr_is(paddr, vosc_pkg::ADDR_TIMING) || addr_is(paddr, vosc_pkg::ADDR_STATUS) ||
                  addr_is(paddr, vosc_pkg::ADDR_INT_STAT) || addr_is(paddr, vosc_pkg::ADDR_INT_MASK);

  always_comb begin
    next_ctrl = ctrl;
    next_dly_samples = dly_samples;
    next_dly_lines = dly_lines;
    next_h_offset = h_offset;
    next_fine_phase = fine_phase;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    next_pready = access;
    next_pslverr = access && !mapped;
    next_prdata = '0;
    if (wr_fire && !pslverr) begin
      if (addr_is(paddr, vosc_pkg::ADDR_CTRL)) begin
        next_ctrl = pwdata[6:0];
      end
      if (addr_is(paddr, vosc_pkg::ADDR_DELAY)) begin
        next_dly_samples = pwdata[9:0];
        next_dly_lines = pwdata[vosc_pkg::DLY_LINE_LSB +: 10];
      end
      if (addr_is(paddr, vosc_pkg::ADDR_TIMING)) begin
        next_h_offset = pwdata[9:0];
        next_fine_phase = pwdata[vosc_pkg::TIM_FINE_LSB +: 9];
      end
      if (addr_is(paddr, vosc_pkg::ADDR_INT_MASK)) begin
        next_int_mask = pwdata[2:0];
      end
      if (addr_is(paddr, vosc_pkg::ADDR_INT_STAT)) begin
        next_int_stat = int_stat & ~pwdata[2:0];
      end
    end
    // Set beats clear
    next_int_stat = next_int_stat | events;
    next_irq = |(next_int_stat & int_mask);
    if (access && !pwrite) begin
      if (addr_is(paddr, vosc_pkg::ADDR_CTRL)) begin
        next_prdata = {25'h000_0000, ctrl};
      end else if (addr_is(paddr, vosc_pkg::ADDR_DELAY)) begin
        next_prdata = {6'h00, dly_lines, 6'h00, dly_samples};
      end else if (addr_is(paddr, vosc_pkg::ADDR_TIMING)) begin
        next_prdata = {7'h00, fine_phase, 6'h00, h_offset};
      end else if (addr_is(paddr, vosc_pkg::ADDR_STATUS)) begin
        next_prdata = {26'h000_0000, out_std_625_out, loss_active_out, ref_present_in,
                       state == VOSC_LOCK, in_presence_in};
      end else if (addr_is(paddr, vosc_pkg::ADDR_INT_STAT)) begin
        next_prdata = {29'h0000_0000, int_stat};
      end else if (addr_is(paddr, vosc_pkg::ADDR_INT_MASK)) begin
        next_prdata = {29'h0000_0000, int_mask};
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= vosc_pkg::CTRL_RESET;
      dly_samples <= 10'h0000;
      dly_lines <= 10'h0000;
      h_offset <= 10'h0000;
      fine_phase <= 9'h000;
      int_stat <= 3'h0;
      int_mask <= 3'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      dly_samples <= next_dly_samples;
      dly_lines <= next_dly_lines;
      h_offset <= next_h_offset;
      fine_phase <= next_fine_phase;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq_out <= next_irq;
    end
  end

  logic wide, lockout, genlock_en;
  logic [1:0] pattern, loss_mode;
  assign wide = ctrl[vosc_pkg::CTRL_WIDE_BIT];
  assign pattern = ctrl[vosc_pkg::CTRL_PAT_LSB +: 2];
  assign loss_mode = ctrl[vosc_pkg::CTRL_LOSS_LSB +: 2];
  assign lockout = ctrl[vosc_pkg::CTRL_LOCKOUT_BIT];
  assign genlock_en = ctrl[vosc_pkg::CTRL_GENLOCK_BIT];

  // ==========================================
  // Front-panel buttons
  logic [2:0] btn_s1, btn_s2, btn_prev;
  logic [2:0] next_press;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_btn
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          btn_s1[gi] <= 1'b0;
          btn_s2[gi] <= 1'b0;
          btn_prev[gi] <= 1'b0;
        end else begin
          btn_s1[gi] <= panel_button_in[gi];
          btn_s2[gi] <= btn_s1[gi];
          btn_prev[gi] <= btn_s2[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    next_press = lockout ? 3'h0 : (btn_s2 & ~btn_prev);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      panel_press_out <= 3'h0;
    end else begin
      panel_press_out <= next_press;
    end
  end

  // ==========================================
  // Input presence and loss tracking
  vosc_state_type next_state;
  logic next_std_625, next_loss;
  logic [2:0] next_events;
  logic pres_ok;
  assign pres_ok = in_presence_in == vosc_pkg::PRES_525 || in_presence_in == vosc_pkg::PRES_625;

  always_comb begin
    next_state = state;
    next_std_625 = out_std_625_out;
    next_events = 3'h0;
    case (state)
      VOSC_IDLE: begin
        if (pres_ok) begin
          next_state = VOSC_LOCK;
        end
      end
      VOSC_LOCK: begin
        if (!pres_ok) begin
          next_state = VOSC_LOST;
          next_events[vosc_pkg::EV_LOSS] = 1'b1;
        end
      end
      VOSC_LOST: begin
        if (pres_ok) begin
          next_state = VOSC_LOCK;
          next_events[vosc_pkg::EV_RESTORE] = 1'b1;
        end
      end
      default: begin
        next_state = VOSC_IDLE;
      end
    endcase
    if (pres_ok) begin
      next_std_625 = in_presence_in == vosc_pkg::PRES_625;
      next_events[vosc_pkg::EV_STD] = state == VOSC_LOCK && next_std_625 != out_std_625_out;
    end
    next_loss = next_state == VOSC_LOST;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= VOSC_IDLE;
      out_std_625_out <= 1'b0;
      loss_active_out <= 1'b0;
      events <= 3'h0;
    end else begin
      state <= next_state;
      out_std_625_out <= next_std_625;
      loss_active_out <= next_loss;
      events <= next_events;
    end
  end

  // ==========================================
  // Output timing
  logic [9:0] out_sample, out_line, next_sample, next_line, spl, lpf, vb_last;
  logic [8:0] next_sch;
  logic genlock_active, frame_start;
  assign genlock_active = genlock_en && ref_present_in;
  assign spl = out_std_625_out ? vosc_pkg::SPL_625 : vosc_pkg::SPL_525;
  assign lpf = out_std_625_out ? vosc_pkg::LINES_625 : vosc_pkg::LINES_525;

  always_comb begin
    frame_start = genlock_active ? ref_frame_start_in : in_frame_start_in;
    next_sample = out_sample + 10'h0001;
    next_line = out_line;
    if (frame_start) begin
      next_sample = h_offset;
      next_line = vosc_pkg::FIRST_LINE + dly_lines;
    end else if (next_sample >= spl) begin
      next_sample = 10'h0000;
      next_line = (out_line >= lpf) ? vosc_pkg::FIRST_LINE : out_line + 10'h0001;
    end
    next_sch = (genlock_active ? ref_sch_phase_in : in_sch_phase_in) + fine_phase;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_sample <= 10'h0000;
      out_line <= vosc_pkg::FIRST_LINE;
      subcarrier_horizontal_phase_out <= 9'h000;
    end else begin
      out_sample <= next_sample;
      out_line <= next_line;
      subcarrier_horizontal_phase_out <= next_sch;
    end
  end

  // ==========================================
  // Delay buffer and video select
  logic [9:0] base_ptr, mem_rdata, next_vid;
  logic mem_we, next_blank;
  assign mem_we = in_valid_in && !(loss_active_out && loss_mode == vosc_pkg::LOSS_FREEZE);

  // Write ahead of read by delay
  vosc_line_mem u_mem (
    .clk_in(ref_clk_in),
    .we_in(mem_we),
    .waddr_in(10'(base_ptr + dly_samples)),
    .wdata_in(in_data_in),
    .raddr_in(base_ptr),
    .rdata_out(mem_rdata)
  );

  always_comb begin
    if (wide) begin
      vb_last = out_std_625_out ? vosc_pkg::VB_WIDE_625 : vosc_pkg::VB_WIDE_525;
    end else begin
      vb_last = out_std_625_out ? vosc_pkg::VB_NARROW_625 : vosc_pkg::VB_NARROW_525;
    end
    next_blank = out_line >= vosc_pkg::FIRST_LINE && out_line <= vb_last;
    next_vid = mem_rdata;
    if (loss_active_out && loss_mode == vosc_pkg::LOSS_MUTE) begin
      next_vid = vosc_pkg::BLACK_LEVEL;
    end
    if (pattern == vosc_pkg::PAT_BLACK) begin
      next_vid = vosc_pkg::BLACK_LEVEL;
    end else if (pattern == vosc_pkg::PAT_BARS) begin
      next_vid = vosc_pkg::BAR_LEVEL[out_sample[9:7]];
    end
    if (next_blank) begin
      next_vid = vosc_pkg::BLACK_LEVEL;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      base_ptr <= 10'h0000;
      vid_data_out <= vosc_pkg::BLACK_LEVEL;
      vid_blank_out <= 1'b1;
    end else begin
      base_ptr <= base_ptr + 10'h0001;
      vid_data_out <= next_vid;
      vid_blank_out <= next_blank;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_narrow_blank;
    !wide && !out_std_625_out && out_line >= 10'h0001 && out_line <= 10'h0009 |=> vid_blank_out;
  endproperty
  a_narrow_blank: assert property (p_narrow_blank) else $error("narrow blank missing");

  property p_wide_edge;
    wide && out_std_625_out && out_line == 10'h0017 |=> !vid_blank_out;
  endproperty
  a_wide_edge: assert property (p_wide_edge) else $error("wide blank too long");

  property p_wide_in;
    wide && !out_std_625_out && out_line == 10'h0014 |=> vid_blank_out;
  endproperty
  a_wide_in: assert property (p_wide_in) else $error("wide blank missing");

  property p_black_pat;
    pattern == vosc_pkg::PAT_BLACK |=> vid_data_out == vosc_pkg::BLACK_LEVEL;
  endproperty
  a_black_pat: assert property (p_black_pat) else $error("black pattern wrong");

  property p_pass;
    pattern == vosc_pkg::PAT_OFF && !next_blank && loss_mode == vosc_pkg::LOSS_NONE
      |=> vid_data_out == $past(mem_rdata);
  endproperty
  a_pass: assert property (p_pass) else $error("video not passed");

  property p_mute;
    loss_active_out && loss_mode == vosc_pkg::LOSS_MUTE && pattern == vosc_pkg::PAT_OFF
      |=> vid_data_out == vosc_pkg::BLACK_LEVEL;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not black");

  property p_freeze;
    loss_active_out && loss_mode == vosc_pkg::LOSS_FREEZE |-> !mem_we;
  endproperty
  a_freeze: assert property (p_freeze) else $error("buffer written while frozen");

  property p_lockout;
    lockout |=> panel_press_out == 3'h0;
  endproperty
  a_lockout: assert property (p_lockout) else $error("press seen under lockout");

  sequence s_loss_drop;
    state == VOSC_LOCK && !pres_ok;
  endsequence
  property p_loss;
    s_loss_drop |=> loss_active_out ##1 int_stat[vosc_pkg::EV_LOSS] [*2];
  endproperty
  a_loss: assert property (p_loss) else $error("loss not flagged");

  property p_std;
    in_presence_in == vosc_pkg::PRES_625 |=> out_std_625_out;
  endproperty
  a_std: assert property (p_std) else $error("standard not followed");

  property p_timing_src;
    !genlock_active && in_frame_start_in |=> out_sample == $past(h_offset);
  endproperty
  a_timing_src: assert property (p_timing_src) else $error("not timed from input");

  property p_ref_phase;
    genlock_active |=> subcarrier_horizontal_phase_out ==
      9'($past(ref_sch_phase_in) + $past(fine_phase));
  endproperty
  a_ref_phase: assert property (p_ref_phase) else $error("phase not matched");
endmodule
`default_nettype wire

// File: testbench/vosc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module vosc_partner (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [1:0] pres_in,
  input wire logic ref_on_in,
  input wire logic frame_in,
  output logic in_valid_out,
  output logic [9:0] in_data_out,
  output logic in_frame_start_out,
  output logic [1:0] in_presence_out,
  output logic [8:0] in_sch_phase_out,
  output logic ref_present_out,
  output logic ref_frame_start_out,
  output logic [8:0] ref_sch_phase_out
);
  // ==========================================
  // Decoded source and house reference
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_valid_out <= 1'b0;
      in_data_out <= 10'h000;
      in_frame_start_out <= 1'b0;
      in_presence_out <= 2'h0;
      in_sch_phase_out <= 9'h000;
      ref_present_out <= 1'b0;
      ref_frame_start_out <= 1'b0;
      ref_sch_phase_out <= 9'h000;
    end else begin
      // Noise-like samples, also while lost
      in_valid_out <= 1'b1;
      in_data_out <= 10'($urandom);
      in_frame_start_out <= frame_in;
      in_presence_out <= pres_in;
      ref_present_out <= ref_on_in;
      ref_frame_start_out <= frame_in;
      // Phases move only at frame start
      if (frame_in) begin
        in_sch_phase_out <= 9'($urandom);
        ref_sch_phase_out <= 9'($urandom);
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/vosc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module vosc_top_test;
  logic ref_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic in_valid_in, in_frame_start_in, ref_present_in, ref_frame_start_in, ref_on, frame;
  logic [9:0] in_data_in, vid_data_out;
  logic [1:0] in_presence_in, pres;
  logic [8:0] in_sch_phase_in, ref_sch_phase_in, subcarrier_horizontal_phase_out, f;
  logic [2:0] panel_button_in, panel_press_out, watch;
  logic vid_blank_out, out_std_625_out, loss_active_out, irq_out;
  logic [9:0] hist [2048];
  logic [9:0] v [4];
  int ecnt = 0;
  int fail_count = 0;
  int n_compared = 0;
  assign watch = {irq_out, out_std_625_out, loss_active_out};

  vosc_top dut (.ref_clk_in, .rstn_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_valid_in, .in_data_in, .in_frame_start_in, .in_presence_in,
    .in_sch_phase_in, .ref_present_in, .ref_frame_start_in, .ref_sch_phase_in,
    .panel_button_in, .panel_press_out, .vid_data_out, .vid_blank_out, .out_std_625_out,
    .subcarrier_horizontal_phase_out, .loss_active_out, .irq_out);
  vosc_partner partner (.clk_in(ref_clk_in), .rstn_in, .pres_in(pres), .ref_on_in(ref_on),
    .frame_in(frame), .in_valid_out(in_valid_in), .in_data_out(in_data_in),
    .in_frame_start_out(in_frame_start_in), .in_presence_out(in_presence_in),
    .in_sch_phase_out(in_sch_phase_in), .ref_present_out(ref_present_in),
    .ref_frame_start_out(ref_frame_start_in), .ref_sch_phase_out(ref_sch_phase_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // Input history for delay expectations
  always @(posedge ref_clk_in) begin
    hist[ecnt % 2048] <= in_data_in;
    ecnt <= ecnt + 1;
  end
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    hang();
  end
  // ==========================================
  // Bench tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    chk("wait bound", 1, 0);
    complete_run();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic wait_on(input int s, input logic val);
    int n = 0;
    while (watch[s] !== val && n < 200) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 200) hang();
  endtask
  function automatic logic [31:0] ctrl(logic w, logic [1:0] p, logic [1:0] l, logic k, logic g);
    return {25'h000_0000, g, k, l, p, w};
  endfunction
  task automatic dchk(input int dl);
    apb(1'b1, vosc_pkg::ADDR_DELAY, 32'(dl));
    tick(dl + 8);
    repeat (4) begin
      @(posedge ref_clk_in);
      chk("delayed", hist[(ecnt - dl - 2) % 2048], vid_data_out);
    end
  endtask
  task automatic blank(input logic w, input logic [1:0] p, input int last, input int spl);
    pres <= p;
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(w, 2'h0, 2'h0, 1'b0, 1'b0));
    wait_on(1, p == vosc_pkg::PRES_625);
    frame <= 1'b1;
    @(posedge ref_clk_in);
    frame <= 1'b0;
    tick((last - 1) * spl + spl / 2);
    chk("last blanked line", 1, vid_blank_out);
    tick(spl);
    chk("first open line", 0, vid_blank_out);
  endtask
  task automatic press(input int b, input logic lk);
    logic [2:0] seen = 3'h0;
    int hits = 0;
    panel_button_in <= 3'(1 << b);
    repeat (8) begin
      @(posedge ref_clk_in);
      seen |= panel_press_out;
      hits += int'(panel_press_out != 3'h0);
    end
    panel_button_in <= 3'h0;
    tick(6);
    chk("press bits", lk ? 32'h0 : 32'(1 << b), seen);
    chk("press count", lk ? 0 : 1, hits);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, frame, ref_on} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pres = vosc_pkg::PRES_525;
    panel_button_in = 3'h0;
    rstn_in = 1'b0;
    void'($urandom(40));
    tick(20);
    chk("reset blank", 1, vid_blank_out);
    chk("reset data", vosc_pkg::BLACK_LEVEL, vid_data_out);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    rdc("ctrl reset", vosc_pkg::ADDR_CTRL, vosc_pkg::CTRL_RESET);
    r = ctrl(1'($urandom), 2'($urandom % 3), 2'($urandom % 3), 1'($urandom), 1'($urandom));
    apb(1'b1, vosc_pkg::ADDR_CTRL, r);
    rdc("ctrl", vosc_pkg::ADDR_CTRL, r);
    apb(1'b0, 8'h40, r);
    chk("bad addr err", 1, er);
    chk("bad addr data", 0, rd);
    apb(1'b1, 8'h44, 32'h0000_0000);
    rdc("ctrl kept", vosc_pkg::ADDR_CTRL, r);
    apb(1'b1, vosc_pkg::ADDR_INT_STAT, 32'h0000_0007);
    apb(1'b1, vosc_pkg::ADDR_INT_MASK, 32'h0000_0004);
    rdc("mask", vosc_pkg::ADDR_INT_MASK, 32'h0000_0004);
    pres <= vosc_pkg::PRES_625;
    wait_on(1, 1'b1);
    wait_on(2, 1'b1);
    apb(1'b0, vosc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0022, rd & 32'h0000_0033);
    apb(1'b1, vosc_pkg::ADDR_INT_STAT, 32'h0000_0004);
    wait_on(2, 1'b0);
    apb(1'b1, vosc_pkg::ADDR_INT_MASK, 32'h0000_0000);
    pres <= vosc_pkg::PRES_525;
    wait_on(1, 1'b0);
    tick(3);
    chk("masked irq", 0, irq_out);
    apb(1'b0, vosc_pkg::ADDR_INT_STAT, 32'h0000_0000);
    chk("std event", 4, rd & 32'h0000_0004);
    apb(1'b1, vosc_pkg::ADDR_INT_MASK, 32'h0000_0007);
    wait_on(2, 1'b1);
    apb(1'b1, vosc_pkg::ADDR_INT_STAT, 32'h0000_0007);
    wait_on(2, 1'b0);
    blank(1'b1, vosc_pkg::PRES_625, vosc_pkg::VB_WIDE_625, vosc_pkg::SPL_625);
    blank(1'b0, vosc_pkg::PRES_625, vosc_pkg::VB_NARROW_625, vosc_pkg::SPL_625);
    blank(1'b1, vosc_pkg::PRES_525, vosc_pkg::VB_WIDE_525, vosc_pkg::SPL_525);
    blank(1'b0, vosc_pkg::PRES_525, vosc_pkg::VB_NARROW_525, vosc_pkg::SPL_525);
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, vosc_pkg::PAT_BLACK, 2'h0, 1'b0, 1'b0));
    tick(8);
    chk("black", vosc_pkg::BLACK_LEVEL, vid_data_out);
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, vosc_pkg::PAT_BARS, 2'h0, 1'b0, 1'b0));
    tick(8);
    chk("bars", 1, vid_data_out inside {vosc_pkg::BAR_LEVEL});
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, vosc_pkg::PAT_OFF, 2'h0, 1'b0, 1'b0));
    dchk(1 + $urandom % 16);
    dchk(vosc_pkg::DELAY_MIN_CYC + 100 + $urandom % 24);
    pres <= vosc_pkg::PRES_NONE;
    wait_on(0, 1'b1);
    dchk(vosc_pkg::DELAY_MIN_CYC + $urandom % 64);
    pres <= vosc_pkg::PRES_525;
    wait_on(0, 1'b0);
    apb(1'b0, vosc_pkg::ADDR_INT_STAT, 32'h0000_0000);
    chk("loss events", 3, rd & 32'h0000_0003);
    apb(1'b1, vosc_pkg::ADDR_INT_STAT, 32'h0000_0007);
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, 2'h0, vosc_pkg::LOSS_MUTE, 1'b0, 1'b0));
    pres <= vosc_pkg::PRES_NONE;
    wait_on(0, 1'b1);
    tick(4);
    chk("muted", vosc_pkg::BLACK_LEVEL, vid_data_out);
    pres <= vosc_pkg::PRES_525;
    wait_on(0, 1'b0);
    dchk(5 + $urandom % 100);
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, 2'h0, vosc_pkg::LOSS_FREEZE, 1'b0, 1'b0));
    pres <= vosc_pkg::PRES_NONE;
    wait_on(0, 1'b1);
    tick(4);
    foreach (v[i]) begin
      @(posedge ref_clk_in);
      v[i] = vid_data_out;
    end
    tick((1 << vosc_pkg::MEM_AW) - 4);
    foreach (v[i]) begin
      @(posedge ref_clk_in);
      chk("frozen", v[i], vid_data_out);
    end
    pres <= vosc_pkg::PRES_525;
    wait_on(0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, 2'h0, 2'h0, k[0], 1'b0));
      for (int b = 0; b < 3; b++) begin
        press(b, k[0]);
      end
    end
    ref_on <= 1'b1;
    f = 9'($urandom);
    apb(1'b1, vosc_pkg::ADDR_TIMING, {7'h00, f, 16'h0000});
    tick(8);
    chk("phase free", 9'(in_sch_phase_in + f), subcarrier_horizontal_phase_out);
    apb(1'b1, vosc_pkg::ADDR_CTRL, ctrl(1'b0, 2'h0, 2'h0, 1'b0, 1'b1));
    tick(8);
    chk("phase lock", 9'(ref_sch_phase_in + f), subcarrier_horizontal_phase_out);
    apb(1'b1, vosc_pkg::ADDR_DELAY, {6'h00, vosc_pkg::VB_NARROW_525, 16'h0000});
    frame <= 1'b1;
    @(posedge ref_clk_in);
    frame <= 1'b0;
    tick(3);
    chk("line offset", 0, vid_blank_out);
    complete_run();
  end
endmodule
`default_nettype wire
